// file: htc_regs.vh
`ifndef HTC_REGS_VH
`define HTC_REGS_VH

// Register byte offsets
`define HTC_ADDR_CTRL      5'h00
`define HTC_ADDR_TOP       5'h04
`define HTC_ADDR_CMP       5'h08
`define HTC_ADDR_COUNT     5'h0C
`define HTC_ADDR_CAPTURE   5'h10
`define HTC_ADDR_IRQ_STAT  5'h14
`define HTC_ADDR_IRQ_MASK  5'h18
`define HTC_ADDR_IRQ_SET   5'h1C

// Control field positions
`define HTC_CTRL_MODE_LO   0
`define HTC_CTRL_MODE_HI   1
`define HTC_CTRL_EN        2
`define HTC_CTRL_DOWN      3
`define HTC_CTRL_CAP_EN    4
`define HTC_CTRL_CLK_SEL   5
`define HTC_CTRL_PRE_LO    6
`define HTC_CTRL_PRE_HI    8
`define HTC_CTRL_RST_EN    9
`define HTC_CTRL_INV       10

// Operating modes
`define HTC_MODE_WDOG      2'h0
`define HTC_MODE_CTC       2'h1
`define HTC_MODE_FAST      2'h2
`define HTC_MODE_PFC       2'h3

// Interrupt bit positions
`define HTC_IRQ_OVF        0
`define HTC_IRQ_MATCH      1
`define HTC_IRQ_CAP        2

// Reset values
`define HTC_CTRL_RESET     16'h0200
`define HTC_TOP_RESET      16'hFFFF
`define HTC_CMP_RESET      16'h8000
`define HTC_MASK_RESET     3'h0

// Synchroniser depth
`define HTC_SYNC_STAGES    2

`endif

// file: htc_sync_edge.v
`timescale 1ns/1ps
`include "htc_regs.vh"
module htc_sync_edge #(
	parameter STAGES = `HTC_SYNC_STAGES
) (
	input  wire clk_i,
	input  wire arst_n_i,
	input  wire async_i,
	output wire rise_o
);
	reg [STAGES-1:0] sh;
	reg              prev;

	// Shift chain; first stage feeds only the second
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sh   <= {STAGES{1'b0}};
			prev <= 1'b0;
		end else begin
			sh   <= {sh[STAGES-2:0], async_i};
			prev <= sh[STAGES-1];
		end
	end

	assign rise_o = sh[STAGES-1] & ~prev;
endmodule

// file: htc_timer.v
`timescale 1ns/1ps
`include "htc_regs.vh"

module htc_timer #(
	parameter        CNT_W       = 16,
	parameter        USE_BUS     = 1,
	parameter [15:0] CTRL_PRESET = `HTC_CTRL_RESET,
	parameter [15:0] TOP_PRESET  = `HTC_TOP_RESET,
	parameter [15:0] CMP_PRESET  = `HTC_CMP_RESET
) (
	input  wire        clk_i,
	input  wire        arst_n_i,
	input  wire [4:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	input  wire        timer_clock_in_i,
	input  wire        timer_reset_n_i,
	input  wire        capture_trigger_in_i,
	output reg         waveform_out_o,
	output reg         timer_irq_out_o,
	output reg         wake_irq_out_o
);
	reg  [15:0]      ctrl;
	reg  [CNT_W-1:0] top;
	reg  [CNT_W-1:0] cmp;
	reg  [CNT_W-1:0] top_a;
	reg  [CNT_W-1:0] cmp_a;
	reg  [CNT_W-1:0] current_count;
	reg  [CNT_W-1:0] capture_value_reg;
	reg  [2:0]       irq_stat;
	reg  [2:0]       irq_mask;
	reg              dir_dn;
	reg              wave;
	reg  [7:0]       pre_cnt;

	reg  [CNT_W-1:0] next_count;
	reg              next_dir_dn;
	reg              next_wave;
	reg              reload;
	reg              ovf_ev;
	reg              match_ev;
	reg  [31:0]      rd_mux;

	wire [1:0] mode    = ctrl[`HTC_CTRL_MODE_HI:`HTC_CTRL_MODE_LO];
	wire [2:0] pre_sel = ctrl[`HTC_CTRL_PRE_HI:`HTC_CTRL_PRE_LO];
	wire       run     = ctrl[`HTC_CTRL_EN];
	wire       is_pwm  = mode[1];
	wire       wr_fire = avs_write_i & ~avs_waitrequest_o;
	wire       bus_wr  = (USE_BUS != 0) & wr_fire;
	wire       clk_rise;
	wire       cap_rise;
	wire       src_tick;
	wire       tick;
	wire [7:0] pre_lim;
	wire       cap_ev;
	wire [2:0] ev;
	wire [2:0] stat_clr;
	wire [2:0] stat_set;
	wire       pin_rst;
	wire [CNT_W-1:0] ones = {CNT_W{1'b1}};
	wire [CNT_W-1:0] zero = {CNT_W{1'b0}};
	wire [CNT_W-1:0] one  = {{(CNT_W-1){1'b0}}, 1'b1};

	function [15:0] be_merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  be;
		begin
			be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	// External count clock, treated as an asynchronous input
	htc_sync_edge #(
		.STAGES(`HTC_SYNC_STAGES)
	) u_clk_edge (
		.clk_i   (clk_i),
		.arst_n_i(arst_n_i),
		.async_i (timer_clock_in_i),
		.rise_o  (clk_rise)
	);

	htc_sync_edge #(
		.STAGES(`HTC_SYNC_STAGES)
	) u_cap_edge (
		.clk_i   (clk_i),
		.arst_n_i(arst_n_i),
		.async_i (capture_trigger_in_i),
		.rise_o  (cap_rise)
	);

	// Source select and prescaler
	assign src_tick = ctrl[`HTC_CTRL_CLK_SEL] ? clk_rise : 1'b1;
	assign pre_lim  = (8'h01 << pre_sel) - 8'h01;
	assign tick     = run & src_tick & (pre_cnt == pre_lim);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_cnt <= 8'h00;
		end else if (!run || tick) begin
			pre_cnt <= 8'h00;
		end else if (src_tick) begin
			pre_cnt <= pre_cnt + 8'h01;
		end
	end

	// Timer reset pin, honoured while its enable bit is set
	assign pin_rst = ctrl[`HTC_CTRL_RST_EN] & ~timer_reset_n_i;

	// Next count per mode
	// Compare match toggles the wave in the non-PWM modes
	always @* begin
		next_count  = current_count;
		next_dir_dn = dir_dn;
		next_wave   = wave;
		reload      = 1'b0;
		ovf_ev      = 1'b0;
		match_ev    = 1'b0;
		if (tick) begin
			match_ev = (current_count == cmp_a);
			case (mode)
			`HTC_MODE_WDOG: begin
				if (ctrl[`HTC_CTRL_DOWN]) begin
					if (current_count == zero) begin
						next_count = top_a;
						ovf_ev     = 1'b1;
					end else begin
						next_count = current_count - one;
					end
				end else if (current_count == top_a) begin
					next_count = zero;
					ovf_ev     = 1'b1;
				end else begin
					next_count = current_count + one;
				end
				if (match_ev) begin
					next_wave = ~wave;
				end
			end
			`HTC_MODE_CTC: begin
				if (match_ev) begin
					next_count = zero;
					next_wave  = ~wave;
				end else if (current_count == ones) begin
					next_count = zero;
					ovf_ev     = 1'b1;
				end else begin
					next_count = current_count + one;
				end
			end
			`HTC_MODE_FAST: begin
				if (current_count >= top_a) begin
					next_count = zero;
					ovf_ev     = 1'b1;
					reload     = 1'b1;
				end else begin
					next_count = current_count + one;
				end
			end
			`HTC_MODE_PFC: begin
				if (dir_dn) begin
					if (current_count == zero) begin
						next_dir_dn = 1'b0;
						next_count  = (top_a == zero) ? zero : one;
						ovf_ev      = 1'b1;
						reload      = 1'b1;
					end else begin
						next_count = current_count - one;
					end
				end else if (current_count >= top_a) begin
					next_dir_dn = 1'b1;
					next_count  = (current_count == zero) ? zero : current_count - one;
				end else begin
					next_count = current_count + one;
				end
			end
			default: begin
				next_count = current_count;
			end
			endcase
		end
		if (is_pwm) begin
			next_wave = (next_count < cmp_a);
		end
	end

	// Counter, active compare and period
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			current_count <= {CNT_W{1'b0}};
			dir_dn        <= 1'b0;
			wave          <= 1'b0;
			top_a         <= TOP_PRESET[CNT_W-1:0];
			cmp_a         <= CMP_PRESET[CNT_W-1:0];
		end else if (pin_rst) begin
			current_count <= {CNT_W{1'b0}};
			dir_dn        <= 1'b0;
			wave          <= 1'b0;
		end else begin
			dir_dn <= next_dir_dn;
			wave   <= next_wave;
			if (bus_wr && avs_address_i == `HTC_ADDR_COUNT) begin
				current_count <= be_merge(current_count, avs_writedata_i,
					avs_byteenable_i);
			end else begin
				current_count <= next_count;
			end
			// Period and compare change only at the cycle boundary in PWM modes while running
			if (!is_pwm || reload || !run) begin
				top_a <= top;
				cmp_a <= cmp;
			end
		end
	end

	// Input capture
	assign cap_ev = (USE_BUS != 0) & ctrl[`HTC_CTRL_CAP_EN] & ~is_pwm & cap_rise;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			capture_value_reg <= {CNT_W{1'b0}};
		end else if (cap_ev) begin
			capture_value_reg <= current_count;
		end
	end

	// Interrupt status: set wins over clear
	assign ev       = {cap_ev, match_ev, ovf_ev};
	assign stat_clr = (bus_wr && avs_address_i == `HTC_ADDR_IRQ_STAT) ?
		avs_writedata_i[2:0] : 3'h0;
	assign stat_set = (bus_wr && avs_address_i == `HTC_ADDR_IRQ_SET) ?
		avs_writedata_i[2:0] : 3'h0;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~stat_clr) | ev | stat_set;
		end
	end

	// Registered outputs; stand-alone shows the overflow pulse
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timer_irq_out_o <= 1'b0;
			wake_irq_out_o  <= 1'b0;
			waveform_out_o  <= 1'b0;
		end else begin
			if (USE_BUS != 0) begin
				timer_irq_out_o <= |(irq_stat & irq_mask);
				wake_irq_out_o  <= |(irq_stat & irq_mask);
			end else begin
				timer_irq_out_o <= ovf_ev;
				wake_irq_out_o  <= ovf_ev;
			end
			waveform_out_o <= wave ^ ctrl[`HTC_CTRL_INV];
		end
	end

	// Software registers; stand-alone keeps the preloaded values
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl     <= CTRL_PRESET;
			top      <= TOP_PRESET[CNT_W-1:0];
			cmp      <= CMP_PRESET[CNT_W-1:0];
			irq_mask <= `HTC_MASK_RESET;
		end else if (bus_wr) begin
			case (avs_address_i)
			`HTC_ADDR_CTRL: begin
				ctrl <= be_merge(ctrl, avs_writedata_i, avs_byteenable_i);
			end
			`HTC_ADDR_TOP: begin
				top <= be_merge(top, avs_writedata_i, avs_byteenable_i);
			end
			`HTC_ADDR_CMP: begin
				cmp <= be_merge(cmp, avs_writedata_i, avs_byteenable_i);
			end
			`HTC_ADDR_IRQ_MASK: begin
				if (avs_byteenable_i[0]) begin
					irq_mask <= avs_writedata_i[2:0];
				end
			end
			default: begin
				irq_mask <= irq_mask;
			end
			endcase
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always @* begin
		rd_mux = 32'h00000000;
		case (avs_address_i)
		`HTC_ADDR_CTRL:     rd_mux = {16'h0000, ctrl};
		`HTC_ADDR_TOP:      rd_mux = {16'h0000, top};
		`HTC_ADDR_CMP:      rd_mux = {16'h0000, cmp};
		`HTC_ADDR_COUNT:    rd_mux = {16'h0000, current_count};
		`HTC_ADDR_CAPTURE:  rd_mux = {16'h0000, capture_value_reg};
		`HTC_ADDR_IRQ_STAT: rd_mux = {29'h00000000, irq_stat};
		`HTC_ADDR_IRQ_MASK: rd_mux = {29'h00000000, irq_mask};
		default:            rd_mux = 32'h00000000;
		endcase
	end

	// Waitrequest drops for one cycle per request
	// Read data changes only when a read is answered
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
			avs_waitrequest_o <= 1'b0;
			if (avs_read_i) begin
				avs_readdata_o <= rd_mux;
			end
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end
endmodule

// file: htc_timer_sva.sv
`timescale 1ns/1ps
`include "htc_regs.vh"
module htc_timer_sva (
	input wire        clk_i,
	input wire        arst_n_i,
	input wire [4:0]  avs_address_i,
	input wire        avs_read_i,
	input wire        avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0]  avs_byteenable_i,
	input wire [31:0] avs_readdata_o,
	input wire        avs_waitrequest_o,
	input wire        timer_reset_n_i,
	input wire        waveform_out_o,
	input wire        timer_irq_out_o,
	input wire        wake_irq_out_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	wire req = avs_read_i | avs_write_i;
	wire ack = req & !avs_waitrequest_o;
	chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	chk_req_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered");
	chk_idle_wait: assert property (!req |=> avs_waitrequest_o)
		else $error("answer without request");
	chk_rd_stable: assert property (avs_waitrequest_o && !avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved");
	chk_wake_dup: assert property (wake_irq_out_o == timer_irq_out_o)
		else $error("wake irq differs");
	chk_wave_rst: assert property (!timer_reset_n_i [*3] |-> !waveform_out_o)
		else $error("wave not cleared");
	chk_mask_off: assert property (ack && avs_write_i && avs_address_i == `HTC_ADDR_IRQ_MASK
		&& avs_byteenable_i[0] && avs_writedata_i[2:0] == 3'h0 |-> ##2 !timer_irq_out_o)
		else $error("irq high with mask clear");
	chk_set_zero: assert property (ack && avs_read_i && avs_address_i == `HTC_ADDR_IRQ_SET
		|-> avs_readdata_o == 32'h0)
		else $error("set register read nonzero");
	cover property (ack && avs_write_i);
	cover property (ack && avs_read_i);
	cover property ($rose(timer_irq_out_o));
endmodule
bind htc_timer htc_timer_sva i_htc_timer_sva (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.timer_reset_n_i, .waveform_out_o, .timer_irq_out_o, .wake_irq_out_o);

// file: htc_far_end.sv
`timescale 1ns/1ps
module htc_far_end (
	input  wire  clk_i,
	output logic tick_o,
	output logic trig_o
);
	initial begin
		tick_o = 1'b0;
		trig_o = 1'b0;
	end
	// Pulses held two cycles so the synchroniser sees each one
	task pulse(input logic cap, input int n);
		repeat (n) begin
			@(posedge clk_i);
			if (cap) trig_o <= 1'b1;
			else tick_o <= 1'b1;
			repeat (2) @(posedge clk_i);
			trig_o <= 1'b0;
			tick_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask
endmodule

// file: htc_timer_tb.sv
`timescale 1ns/1ps
`include "htc_regs.vh"
module htc_timer_tb;
	logic        clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [4:0]  adr = 5'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        wait_o;
	logic        rst_n = 1'b1;
	logic        tick;
	logic        trig;
	logic        wave;
	logic        irq;
	logic        wake;
	logic [15:0] seed = 16'h0034;
	logic [31:0] rv [8] = '{32'h200, 32'hFFFF, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	int          n_fail = 0;
	int          compares = 0;
	int          hi;
	int          per;
	int          n_ovf;
	logic        sa_irq;
	always #2 clk_i = ~clk_i;
	htc_timer #(.USE_BUS(0), .CTRL_PRESET(16'h0204), .TOP_PRESET(16'h0009)) i_htc_timer_sa (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(5'h00), .avs_read_i(1'b0),
		.avs_write_i(1'b0), .avs_writedata_i(32'h0), .avs_byteenable_i(4'h0),
		.avs_readdata_o(), .avs_waitrequest_o(), .timer_clock_in_i(1'b0),
		.timer_reset_n_i(rst_n), .capture_trigger_in_i(trig), .waveform_out_o(),
		.timer_irq_out_o(sa_irq), .wake_irq_out_o());
	htc_timer i_htc_timer (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h3),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .timer_clock_in_i(tick),
		.timer_reset_n_i(rst_n), .capture_trigger_in_i(trig), .waveform_out_o(wave),
		.timer_irq_out_o(irq), .wake_irq_out_o(wake));
	htc_far_end i_htc_far_end (.clk_i(clk_i), .tick_o(tick), .trig_o(trig));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int exp_hi(input int m, input int cmp);
		return m == 2 ? 2 * cmp : 2 * (2 * cmp - 1);
	endfunction
	task end_of_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (k > 50) begin
				n_fail++;
				end_of_test();
			end
		end while (wait_o !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_i);
	endtask
	task wirq;
		int k;
		k = 0;
		while (irq !== 1'b1) begin
			@(posedge clk_i);
			k++;
			if (k > 200) begin
				n_fail++;
				end_of_test();
			end
		end
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		foreach (rv[i]) begin
			bus(0, 5'(i * 4), 0);
			check(q, rv[i]);
		end
		$display("reset values done");
		n_ovf = 0;
		repeat (100) begin
			@(posedge clk_i);
			n_ovf += sa_irq;
		end
		check(n_ovf, 10);
		$display("stand-alone done");
		bus(1, `HTC_ADDR_CTRL, 32'h264);
		i_htc_far_end.pulse(1'b0, 10);
		repeat (4) @(posedge clk_i);
		bus(1, `HTC_ADDR_CTRL, 32'h200);
		bus(0, `HTC_ADDR_COUNT, 0);
		check(q, 32'h5);
		for (int a = 1; a < 3; a++) begin
			seed = lfsr(seed);
			bus(1, 5'(a * 4), {16'h0, seed});
			bus(0, 5'(a * 4), 0);
			check(q, {16'h0, seed});
		end
		$display("clock source and registers done");
		seed = lfsr(seed);
		bus(1, `HTC_ADDR_COUNT, {16'h0, seed});
		bus(1, `HTC_ADDR_CTRL, 32'h210);
		i_htc_far_end.pulse(1'b1, 1);
		bus(1, `HTC_ADDR_CAPTURE, 32'h0);
		bus(0, `HTC_ADDR_CAPTURE, 0);
		check(q, {16'h0, seed});
		bus(0, `HTC_ADDR_IRQ_STAT, 0);
		check(q, 32'h4);
		bus(1, `HTC_ADDR_IRQ_STAT, 32'h7);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n <= 1'b1;
		bus(0, `HTC_ADDR_COUNT, 0);
		check(q, 32'h0);
		bus(1, `HTC_ADDR_CTRL, 32'h600);
		@(posedge clk_i);
		check(wave, 1'b1);
		bus(1, `HTC_ADDR_CTRL, 32'h212);
		i_htc_far_end.pulse(1'b1, 1);
		bus(0, `HTC_ADDR_IRQ_STAT, 0);
		check(q, 32'h0);
		$display("capture done");
		bus(1, `HTC_ADDR_TOP, 32'h9);
		bus(1, `HTC_ADDR_CMP, 32'h4);
		for (int m = 2; m < 4; m++) begin
			per = m == 2 ? 10 : 18;
			bus(1, `HTC_ADDR_CTRL, 32'h204 | m);
			repeat (40) @(posedge clk_i);
			hi = 0;
			repeat (2 * per) begin
				@(posedge clk_i);
				hi += wave;
			end
			check(hi, exp_hi(m, 4));
		end
		$display("pwm done");
		for (int m = 0; m < 2; m++) begin
			bus(1, `HTC_ADDR_CTRL, 32'h200);
			bus(1, `HTC_ADDR_COUNT, 32'h0);
			bus(1, `HTC_ADDR_IRQ_STAT, 32'h7);
			bus(1, `HTC_ADDR_IRQ_MASK, 32'h1 << m);
			check(irq, 1'b0);
			bus(1, `HTC_ADDR_CTRL, m ? 32'h205 : 32'h20C);
			wirq();
			check(irq, 1'b1);
			bus(0, `HTC_ADDR_IRQ_STAT, 0);
			check(q[m], 1'b1);
		end
		bus(1, `HTC_ADDR_CTRL, 32'h200);
		bus(1, `HTC_ADDR_IRQ_MASK, 32'h0);
		bus(1, `HTC_ADDR_IRQ_STAT, 32'h7);
		bus(1, `HTC_ADDR_IRQ_MASK, 32'h2);
		check(irq, 1'b0);
		bus(1, `HTC_ADDR_IRQ_SET, 32'h2);
		bus(0, `HTC_ADDR_IRQ_SET, 0);
		check(q, 32'h0);
		check(irq, 1'b1);
		check(wake, 1'b1);
		bus(1, `HTC_ADDR_IRQ_STAT, 32'h2);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0);
		$display("interrupts done");
		end_of_test();
	end
endmodule
